//--- include/gpb_params.svh
// Timing counts and channel constants for the expansion bus I/O and DMA strobe block
`ifndef GPB_PARAMS_SVH
`define GPB_PARAMS_SVH
`define GPB_CLK_PERIOD_NS     100
`define GPB_SETUP_NS          100
`define GPB_SETUP_CYC         ((`GPB_SETUP_NS + `GPB_CLK_PERIOD_NS - 1) / `GPB_CLK_PERIOD_NS)
`define GPB_STROBE_NS         300
`define GPB_STROBE_CYC        ((`GPB_STROBE_NS + `GPB_CLK_PERIOD_NS - 1) / `GPB_CLK_PERIOD_NS)
`define GPB_HOLD_NS           100
`define GPB_HOLD_CYC          ((`GPB_HOLD_NS + `GPB_CLK_PERIOD_NS - 1) / `GPB_CLK_PERIOD_NS)
`define GPB_NUM_CHAN          7
`define GPB_NUM_LINES         4
`define GPB_CHAN_NONE         3'h7
`endif

//--- include/gpb_pkg.sv
// Types for the expansion bus I/O and DMA strobe block
package gpb_pkg;
    typedef enum logic [1:0] {
        GPB_TGT_EXT_IO,
        GPB_TGT_EXT_MEM,
        GPB_TGT_ROM,
        GPB_TGT_INTERNAL
    } gpb_target_t;

    typedef struct packed {
        logic        valid;     // Cycle request
        logic        write;     // 1 write, 0 read
        gpb_target_t target;    // Where the cycle goes
        logic        dmaCycle;  // Cycle is a DMA transfer
        logic [2:0]  dmaChan;   // Internal channel served in a DMA cycle
    } gpb_req_t;

    typedef struct packed {
        logic        done;      // One-cycle pulse at end of cycle
        logic        wide;      // Transfer was 16 bits
    } gpb_rsp_t;

    typedef struct packed {
        logic        ioReadStrobeN;
        logic        ioWriteStrobeN;
        logic        dataTransceiverOeN;
        logic        bootRomBufferOeN;
        logic [3:0]  dmaAckLineN;
        logic        dmaCycleAddressEnable;
    } gpb_pins_t;

    typedef enum logic [1:0] { GPB_IDLE, GPB_SETUP, GPB_STROBE, GPB_HOLD } gpb_phase_t;
endpackage

//--- rtl/gpb_dma_map.sv
// Mapping of external DMA request lines onto internal channels
`timescale 1ns/1ns
`include "gpb_params.svh"
module gpb_dma_map (
    input  wire logic       sys_clk,
    input  wire logic       reset_n,
    input  wire logic [3:0] dmaReqPin,      // Raw request pins, high active
    input  wire logic [11:0] reqChanMap,    // 3 bits per line, channel or none
    output logic [6:0]      chanReq         // Pending request per internal channel
);
    import gpb_pkg::*;

    typedef struct packed {
        logic [3:0] meta;   // First synchroniser stage
        logic [3:0] sync;   // Second stage, the only one read
    } gpb_map_state_t;

    gpb_map_state_t st_ff;
    gpb_map_state_t nxt_st;

    // Synchronise the asynchronous request pins
    always_comb begin
        nxt_st      = st_ff;
        nxt_st.meta = dmaReqPin;
        nxt_st.sync = st_ff.meta;
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Each line lands on whichever channel it maps to; a high level is pending
    always_comb begin
        chanReq = 7'h00;
        for (int i = 0; i < `GPB_NUM_LINES; i++) begin
            if (st_ff.sync[i] && reqChanMap[i*3 +: 3] != `GPB_CHAN_NONE) begin
                chanReq[reqChanMap[i*3 +: 3]] = 1'b1;
            end
        end
    end
endmodule

//--- rtl/gpb_io_dma_strobes.sv
// Expansion bus I/O strobes, transceiver enables, 16-bit sizing and DMA handshakes
// Functional notes
// - DMA acknowledge lines are driven active low
// - Any request line maps to any channel
// - Transceiver enable asserted on external accesses
// - Transceiver enable stays off for internal accesses
// - Boot ROM uses its own buffer enable
// - Read strobe asserted for I/O reads
// - Write strobe asserted for I/O writes
// - Any acknowledge line maps to any channel
`timescale 1ns/1ns
`include "gpb_params.svh"
module gpb_io_dma_strobes (
    input  wire logic           sys_clk,
    input  wire logic           reset_n,
    input  wire gpb_pkg::gpb_req_t cycleReq,      // Cycle request from the bus core
    output gpb_pkg::gpb_rsp_t   cycleRsp,         // Completion and size
    output logic                cycleReady,       // Request accepted when high
    input  wire logic [3:0]     dmaReqPin,        // dma_req_line_0..3 pins
    input  wire logic [11:0]    reqChanMap,       // Request line to channel map
    input  wire logic [11:0]    ackChanMap,       // Acknowledge line to channel map
    output logic [6:0]          chanReq,          // Pending requests per channel
    input  wire logic           ioWideSelectN,    // io_wide_select pin, low active
    input  wire logic           echoMode,         // Echo mode select; internal cycles still keep the transceiver off
    output gpb_pkg::gpb_pins_t  busPins           // Strobes and enables, low active except the high-active address enable
);
    import gpb_pkg::*;

    // Whole state of the sequencer in one struct
    typedef struct packed {
        gpb_phase_t  phase;      // Cycle phase
        logic [1:0]  cnt;        // Cycles left in phase
        gpb_req_t    req;        // Captured request
        logic [1:0]  wideSync;   // Wide select synchroniser
        logic        wide;       // Sampled size of current cycle
        gpb_rsp_t    rsp;        // Registered answer
        gpb_pins_t   pins;       // Registered pin levels
    } gpb_state_t;

    // Registered state and its next value
    gpb_state_t st_ff;
    gpb_state_t nxt_st;

    // Phase lengths in clocks, loaded as count minus one so that zero ends the phase.
    // Two bits hold up to four clocks; longer settings would need a wider counter.
    // Setup gives the target time to decode and claim a wide transfer.
    localparam logic [1:0] SETUP_CNT  = 2'(`GPB_SETUP_CYC - 1);
    localparam logic [1:0] STROBE_CNT = 2'(`GPB_STROBE_CYC - 1);
    localparam logic [1:0] HOLD_CNT   = 2'(`GPB_HOLD_CYC - 1);

    // Acknowledge level for one line given the channel being served
    function automatic logic ackFor(input logic [2:0] map, input logic dma,
                                    input logic [2:0] chan);
        ackFor = dma && map != `GPB_CHAN_NONE && map == chan;
    endfunction

    // One step down the phase counter, shared by every timed phase
    function automatic logic [1:0] cntDown(input logic [1:0] cnt);
        cntDown = cnt - 2'h1;
    endfunction

    // Low-active strobe for one direction; only plain external I/O cycles strobe
    function automatic logic ioStrobeN(input logic on, input gpb_req_t req,
                                       input logic wr);
        ioStrobeN = ~(on && req.target == GPB_TGT_EXT_IO && req.write == wr
                      && !req.dmaCycle);
    endfunction

    // Request synchroniser and channel mapping
    // Only mapped, synchronised levels reach the channel outputs
    gpb_dma_map gpb_dma_map_inst (
        .sys_clk    (sys_clk),
        .reset_n    (reset_n),
        .dmaReqPin  (dmaReqPin),
        .reqChanMap (reqChanMap),
        .chanReq    (chanReq)
    );

    // Ready only in idle; a request held while busy simply waits
    assign cycleReady = (st_ff.phase == GPB_IDLE);
    // Answer and pins come straight from flip-flops, free of glitches
    assign cycleRsp   = st_ff.rsp;
    assign busPins    = st_ff.pins;

    // Next-state logic for the cycle sequencer and pins
    always_comb begin
        logic ext;
        logic strobeOn;
        ext              = 1'b0;
        strobeOn         = 1'b0;
        // Defaults: hold state, shift the select synchroniser, drop the done pulse
        nxt_st           = st_ff;
        nxt_st.wideSync  = {st_ff.wideSync[0], ~ioWideSelectN};
        nxt_st.rsp.done  = 1'b0;
        // Every phase code is in use, so the case needs no default
        unique case (st_ff.phase)
            GPB_IDLE: begin
                // Capture the whole request so later changes cannot disturb the cycle
                if (cycleReq.valid) begin
                    nxt_st.req   = cycleReq;
                    nxt_st.phase = GPB_SETUP;
                    nxt_st.cnt   = SETUP_CNT;
                    nxt_st.wide  = 1'b0;
                end
            end
            GPB_SETUP: begin
                // Target answers size early; late assertion is not honoured
                if (st_ff.cnt == 2'h0) begin
                    nxt_st.wide  = st_ff.wideSync[1];
                    nxt_st.phase = GPB_STROBE;
                    nxt_st.cnt   = STROBE_CNT;
                end else begin
                    // Still waiting for the target to settle
                    nxt_st.cnt = cntDown(st_ff.cnt);
                end
            end
            GPB_STROBE: begin
                // Strobe stands for its full count before the hold phase
                if (st_ff.cnt == 2'h0) begin
                    nxt_st.phase = GPB_HOLD;
                    nxt_st.cnt   = HOLD_CNT;
                end else begin
                    nxt_st.cnt = cntDown(st_ff.cnt);
                end
            end
            GPB_HOLD: begin
                // Data stays valid after the strobe; done pulses as the bus goes idle
                if (st_ff.cnt == 2'h0) begin
                    nxt_st.phase    = GPB_IDLE;
                    nxt_st.rsp.done = 1'b1;
                    nxt_st.rsp.wide = st_ff.wide;
                    // Clearing the request lets every pin fall back to idle
                    nxt_st.req      = '0;
                end else begin
                    nxt_st.cnt = cntDown(st_ff.cnt);
                end
            end
        endcase
        // Pins follow the phase being entered so they leave flip-flops cleanly
        // Taking them from the current phase would lag every pin by one clock
        ext      = nxt_st.phase != GPB_IDLE;
        strobeOn = nxt_st.phase == GPB_STROBE;
        // DMA cycles select the device by acknowledge, so they get no strobe
        nxt_st.pins.ioReadStrobeN  = ioStrobeN(strobeOn, nxt_st.req, 1'b0);
        nxt_st.pins.ioWriteStrobeN = ioStrobeN(strobeOn, nxt_st.req, 1'b1);
        // Echo mode never opens the transceiver for internal cycles
        nxt_st.pins.dataTransceiverOeN = ~(ext && (nxt_st.req.target == GPB_TGT_EXT_IO
                                           || nxt_st.req.target == GPB_TGT_EXT_MEM));
        nxt_st.pins.bootRomBufferOeN = ~(ext && nxt_st.req.target == GPB_TGT_ROM);
        // Address enable covers the whole DMA cycle so I/O decoders stay quiet
        nxt_st.pins.dmaCycleAddressEnable = ext && nxt_st.req.dmaCycle;
        // Every line mapped to the served channel acknowledges together
        for (int i = 0; i < `GPB_NUM_LINES; i++) begin
            nxt_st.pins.dmaAckLineN[i] = ~ackFor(ackChanMap[i*3 +: 3], ext && nxt_st.req.dmaCycle,
                                                 nxt_st.req.dmaChan);
        end
        // Echo mode on an internal cycle also forces the transceiver enable off
        if (echoMode && nxt_st.req.target == GPB_TGT_INTERNAL) begin
            nxt_st.pins.dataTransceiverOeN = 1'b1;
        end
    end

    // State register; pins idle high except the address enable
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            // Clear everything, then raise the low-active pins to their idle level
            st_ff                             <= '0;
            st_ff.pins.ioReadStrobeN          <= 1'b1;
            st_ff.pins.ioWriteStrobeN         <= 1'b1;
            st_ff.pins.dataTransceiverOeN     <= 1'b1;
            st_ff.pins.bootRomBufferOeN       <= 1'b1;
            st_ff.pins.dmaAckLineN            <= 4'hf;
        end else begin
            st_ff <= nxt_st;
        end
    end
endmodule

//--- sim/gpb_io_dma_props.sv
// Assertions on the I/O strobes, enables and DMA handshakes
`timescale 1ns/1ns
module gpb_io_dma_props (
    input wire logic               sys_clk,
    input wire logic               reset_n,
    input wire gpb_pkg::gpb_req_t  cycleReq,
    input wire gpb_pkg::gpb_rsp_t  cycleRsp,
    input wire logic               cycleReady,
    input wire logic [3:0]         dmaReqPin,
    input wire logic [11:0]        reqChanMap,
    input wire logic [11:0]        ackChanMap,
    input wire logic [6:0]         chanReq,
    input wire logic               ioWideSelectN,
    input wire logic               echoMode,
    input wire gpb_pkg::gpb_pins_t busPins
);
    import gpb_pkg::*;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    wire tk = cycleReady && cycleReq.valid;  // Request taken at this edge
    wire io = tk && cycleReq.target == GPB_TGT_EXT_IO && !cycleReq.dmaCycle;
    wire dm = tk && cycleReq.dmaCycle;       // DMA cycle taken
    wire ex = tk && (cycleReq.target inside {GPB_TGT_EXT_IO, GPB_TGT_EXT_MEM});
    rd_strobe_a: assert property (io && !cycleReq.write
        |-> ##2 !busPins.ioReadStrobeN[*3] ##1 busPins.ioReadStrobeN) else $error("read strobe");
    wr_strobe_a: assert property (io && cycleReq.write
        |-> ##2 !busPins.ioWriteStrobeN[*3] ##1 busPins.ioWriteStrobeN) else $error("write strobe");
    ext_oe_a: assert property (ex
        |-> ##1 !busPins.dataTransceiverOeN[*5]) else $error("oe off on external");
    int_oe_a: assert property (tk && cycleReq.target == GPB_TGT_INTERNAL
        |-> ##1 busPins.dataTransceiverOeN[*5]) else $error("oe on internal");
    rom_buf_a: assert property (tk && cycleReq.target == GPB_TGT_ROM
        |-> ##1 !busPins.bootRomBufferOeN && busPins.dataTransceiverOeN) else $error("rom enable");
    ack_low_a: assert property (dm && cycleReq.dmaChan == ackChanMap[8:6]
        && ackChanMap[8:6] != 3'h7
        |-> ##1 !busPins.dmaAckLineN[2] && busPins.dmaCycleAddressEnable) else $error("ack");
    ack_map_a: assert property (dm && cycleReq.dmaChan != ackChanMap[2:0]
        |-> ##1 busPins.dmaAckLineN[0]) else $error("ack on unmapped line");
    req_map_a: assert property ((reqChanMap[8:6] != 3'h7 && $stable(reqChanMap)
        && dmaReqPin[2])[*3] |-> chanReq[reqChanMap[8:6]]) else $error("request map");
    // Size is the select level one clock before the take, seen through the synchroniser
    wide_size_a: assert property (tk
        |-> ##6 cycleRsp.done && cycleRsp.wide != $past(ioWideSelectN, 7)) else $error("size");
    rd_c: cover property (io && !cycleReq.write);
    wr_c: cover property (io && cycleReq.write);
    dma_c: cover property (dm);
    wide_c: cover property (cycleRsp.done && cycleRsp.wide);
endmodule
bind gpb_io_dma_strobes gpb_io_dma_props gpb_io_dma_props_inst (.sys_clk(sys_clk),
    .reset_n(reset_n), .cycleReq(cycleReq), .cycleRsp(cycleRsp), .cycleReady(cycleReady),
    .dmaReqPin(dmaReqPin), .reqChanMap(reqChanMap), .ackChanMap(ackChanMap),
    .chanReq(chanReq), .ioWideSelectN(ioWideSelectN), .echoMode(echoMode), .busPins(busPins));

//--- sim/gpb_peer.sv
// Model of a peripheral that requests DMA and claims wide I/O
`timescale 1ns/1ns
module gpb_peer (
    input wire logic [3:0]         wantReq,
    input wire logic               wantWide,
    input wire gpb_pkg::gpb_pins_t busPins,
    output logic [3:0]             dmaReqPin,
    output logic                   ioWideSelectN
);
    // Requests are plain high levels
    assign dmaReqPin = wantReq;
    // Silent while the address enable marks a DMA cycle
    assign ioWideSelectN = !(wantWide && !busPins.dmaCycleAddressEnable);
endmodule

//--- sim/gpb_io_dma_strobes_bench.sv
// Self-checking bench for the I/O and DMA strobe block
`timescale 1ns/1ns
`include "gpb_params.svh"
module gpb_io_dma_strobes_bench;
    import gpb_pkg::*;
    logic sys_clk = 0, reset_n = 0, echoMode = 0, wantWide = 0;
    logic [3:0] wantReq = 4'h0, dmaReqPin, sAck;
    logic [11:0] reqChanMap = 12'hf7f, ackChanMap = 12'hf7f;  // Line 2 on channel 5
    logic [6:0] chanReq;
    logic ioWideSelectN, cycleReady, sRd, sWr, sOe, sRom, sAen, done;
    gpb_req_t cycleReq = '0;
    gpb_rsp_t cycleRsp;
    gpb_pins_t busPins;
    int err_count = 0, checks = 0, cyc = 0, nLow = 0;  // Clocks to done, strobe-low clocks
    always #50 sys_clk = ~sys_clk;
    gpb_io_dma_strobes gpb_io_dma_strobes_inst (.sys_clk(sys_clk), .reset_n(reset_n),
        .cycleReq(cycleReq), .cycleRsp(cycleRsp), .cycleReady(cycleReady),
        .dmaReqPin(dmaReqPin), .reqChanMap(reqChanMap), .ackChanMap(ackChanMap),
        .chanReq(chanReq), .ioWideSelectN(ioWideSelectN), .echoMode(echoMode),
        .busPins(busPins));
    gpb_peer gpb_peer_inst (.wantReq(wantReq), .wantWide(wantWide), .busPins(busPins),
        .dmaReqPin(dmaReqPin), .ioWideSelectN(ioWideSelectN));
    task print_verdict;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input logic ok, input string m);
        checks++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask
    // One cycle, noting every pin that went active until done
    task run(input logic wr, input gpb_target_t tg, input logic dm);
        {sRd, sWr, sOe, sRom, sAen, done, sAck} = '0;
        cyc = 0;
        nLow = 0;
        @(negedge sys_clk);
        chk(cycleReady === 1'b1, "not ready in idle");
        cycleReq = '{1'b1, wr, tg, dm, 3'h5};
        @(negedge sys_clk);
        cycleReq.valid = 1'b0;  // Ready is high in idle, so it was taken
        chk(cycleReady === 1'b0, "ready while busy");
        for (int n = 0; n < 12 && !done; n++) begin
            @(negedge sys_clk);
            sRd |= !busPins.ioReadStrobeN;
            sWr |= !busPins.ioWriteStrobeN;
            sOe |= !busPins.dataTransceiverOeN;
            sRom |= !busPins.bootRomBufferOeN;
            sAen |= busPins.dmaCycleAddressEnable;
            sAck |= ~busPins.dmaAckLineN;
            done = cycleRsp.done;
            cyc++;
            nLow += !(busPins.ioReadStrobeN && busPins.ioWriteStrobeN);
        end
        if (!done) begin
            chk(1'b0, "no done");
            print_verdict;
        end
        chk(cyc == `GPB_SETUP_CYC + `GPB_STROBE_CYC + `GPB_HOLD_CYC, "cycle length");
    endtask
    task t_read;
        wantWide = 1;
        repeat (3) @(negedge sys_clk);
        run(0, GPB_TGT_EXT_IO, 0);
        chk(sRd && !sWr && sOe, "read");
        chk(nLow == `GPB_STROBE_CYC, "read strobe width");
        chk(cycleRsp.wide === 1'b1, "not wide");
    endtask
    task t_write;
        wantWide = 0;
        repeat (3) @(negedge sys_clk);
        run(1, GPB_TGT_EXT_IO, 0);
        chk(sWr && !sRd && sOe, "write");
        chk(nLow == `GPB_STROBE_CYC, "write strobe width");
        chk(cycleRsp.wide === 1'b0, "wide");
    endtask
    task t_mem_rom_int;
        run(0, GPB_TGT_EXT_MEM, 0);
        chk(sOe && !sRd && !sRom, "memory");
        run(0, GPB_TGT_ROM, 0);
        chk(sRom && !sOe, "rom");
        echoMode = 1;  // Echo must not open the transceiver
        run(1, GPB_TGT_INTERNAL, 0);
        chk(!sOe && !sWr && !sRom, "internal");
        echoMode = 0;
    endtask
    // Line 2 walked over all seven channels, then two DMA cycles
    task t_dma;
        for (int c = 0; c < 7; c++) begin
            reqChanMap = {3'h7, c[2:0], 6'h3f};
            wantReq = 4'h4;
            repeat (4) @(negedge sys_clk);
            chk(chanReq === 7'(1 << c), "request map");
            wantReq = 4'h0;
            repeat (4) @(negedge sys_clk);
            chk(chanReq === 7'h00, "request stuck");
        end
        run(0, GPB_TGT_EXT_IO, 1);
        chk(sAck === 4'h4 && sAen && !sRd, "dma ack");
        ackChanMap = 12'hf6b;  // Line 0 on channel 3, lines 1 and 2 on channel 5
        run(1, GPB_TGT_EXT_IO, 1);
        chk(sAck === 4'h6 && sAen && !sWr, "dma ack map");
    endtask
    initial begin
        repeat (10) @(negedge sys_clk);
        reset_n = 1;
        t_read;
        t_write;
        t_mem_rom_int;
        t_dma;
        print_verdict;
    end
endmodule
